// *** design/bcf_config_bank.sv ***
module bcf_config_bank #(
  parameter int LAG_CYCLES  = bcf_pkg::LAG_CYCLES,
  parameter int GLOBAL_SAMPLE_STATE_CYCLES = bcf_pkg::GLOBAL_SAMPLE_STATE_CYCLES
) (
  // Clock and hard reset
  input  wire logic                                 i_clk,
  input  wire logic                                 i_rst,
  // Serial port pins
  input  wire bcf_pkg::bcf_spi_in_t                 i_spi,
  output bcf_pkg::bcf_spi_out_t                     o_spi,
  // Frame control
  input  wire logic                                 i_exposure_request,
  input  wire logic                                 i_exposure_end,
  input  wire logic                                 i_readout_done,
  // Frame status and configuration
  output bcf_pkg::bcf_frame_state_t                 o_frame_state,
  output logic                                      o_exposure_overlap,
  output logic                                      o_integrating,
  output logic [bcf_pkg::SYNC_COUNT-1:0][7:0]       o_active_sync,
  output logic [bcf_pkg::FRAME_COUNT-1:0][7:0]      o_frame_timing
);

  typedef struct packed {
    logic [2:0]                                     sclk_s;
    logic [2:0]                                     csn_s;
    logic [2:0]                                     mosi_s;
    logic [2:0]                                     req_s;
    logic                                           sclk_f;
    logic                                           csn_f;
    logic                                           req_f;
    logic [3:0]                                     bit_cnt;
    logic                                           is_write;
    logic                                           commit;
    logic [6:0]                                     addr;
    logic [7:0]                                     shift_in;
    logic [7:0]                                     shift_out;
    bcf_pkg::bcf_spi_out_t                          spi;
    logic [1:0]                                     bank_ptr;
    logic [bcf_pkg::NUM_BANKS-1:0][127:0][7:0]      mem;
    logic [bcf_pkg::SYNC_COUNT-1:0][7:0]            active;
    logic [bcf_pkg::FRAME_COUNT-1:0][7:0]           frame_cfg;
    bcf_pkg::bcf_frame_state_t                      state;
    logic                                           exp_run;
    logic                                           exp_done;
    logic                                           integ;
    logic                                           lag_pend;
    logic [bcf_pkg::CNT_W-1:0]                      lag_cnt;
    logic [bcf_pkg::CNT_W-1:0]                      global_sample_state_cnt;
  } bcf_state_t;

  localparam logic [bcf_pkg::CNT_W-1:0] LAG_LAST  = bcf_pkg::CNT_W'(LAG_CYCLES - 1);
  localparam logic [bcf_pkg::CNT_W-1:0] GLOBAL_SAMPLE_STATE_LAST = bcf_pkg::CNT_W'(GLOBAL_SAMPLE_STATE_CYCLES - 1);

  bcf_state_t q;
  bcf_state_t d;

  // Filtered level: moves only once stages two and three agree
  function automatic logic filt(input logic [2:0] s, input logic f);
    filt = (s[1] == s[2]) ? s[2] : f;
  endfunction : filt

  // Index into a category window, valid flag in the top bit
  function automatic logic [7:0] win_idx(input logic [6:0] a, input logic [6:0] first,
                                         input int count);
    logic [6:0] off;
    off     = a - first;
    win_idx = {(a >= first) && (32'(off) < count), off};
  endfunction : win_idx

  // Read mux: pointer, status, else stored (last written) value
  function automatic logic [7:0] read_reg(input bcf_state_t s, input logic [6:0] a);
    read_reg = s.mem[s.bank_ptr][a];
    if (a == bcf_pkg::ADDR_BANK_POINTER)
      read_reg = {6'h00, s.bank_ptr};
    else if (s.bank_ptr == 2'h0 && a == bcf_pkg::ADDR_FRAME_STATUS)
      read_reg = {3'h0, s.integ, s.exp_run, 3'(s.state)};
  endfunction : read_reg

  // Control bits straight from bank 0
  logic fs_disable;
  logic upd_hold;
  logic soft_n;
  logic no_lag;
  assign fs_disable = q.mem[0][bcf_pkg::ADDR_FRAME_SYNC_DISABLE][bcf_pkg::CTRL_BIT];
  assign upd_hold   = q.mem[0][bcf_pkg::ADDR_UPDATE_HOLD][bcf_pkg::CTRL_BIT];
  assign soft_n     = q.mem[0][bcf_pkg::ADDR_SOFT_RESET_CONTROL][bcf_pkg::CTRL_BIT];
  assign no_lag     = q.mem[0][bcf_pkg::ADDR_START_LAG_DISABLE][bcf_pkg::CTRL_BIT];

  // Next-state logic for port, banks and frame controller
  always_comb
  begin
    logic       sclk_n;
    logic       csn_n;
    logic       req_n;
    logic       rise;
    logic       fall;
    logic       req_rise;
    logic       to_global_sample_state;
    logic       start_exp;
    logic [6:0] a;
    logic [7:0] rd;
    logic [7:0] wi;
    sclk_n    = filt(q.sclk_s, q.sclk_f);
    csn_n     = filt(q.csn_s, q.csn_f);
    req_n     = filt(q.req_s, q.req_f);
    rise      = sclk_n & ~q.sclk_f;
    fall      = ~sclk_n & q.sclk_f;
    req_rise  = req_n & ~q.req_f;
    to_global_sample_state   = 1'b0;
    start_exp = 1'b0;
    a         = q.addr;
    rd        = 8'h00;
    wi        = 8'h00;
    d         = q;

    // Three-stage pin synchronisers
    d.sclk_s = {q.sclk_s[1:0], i_spi.sclk};
    d.csn_s  = {q.csn_s[1:0], i_spi.csn};
    d.mosi_s = {q.mosi_s[1:0], i_spi.mosi};
    d.req_s  = {q.req_s[1:0], i_exposure_request};
    d.sclk_f = sclk_n;
    d.csn_f  = csn_n;
    d.req_f  = req_n;

    // Serial port: deselect drops the access and floats the data pin
    if (csn_n)
    begin
      d.bit_cnt     = 4'h0;
      d.commit      = 1'b0;
      d.spi.miso_oe = 1'b0;
      d.spi.miso    = 1'b0;
    end
    else if (rise)
    begin
      if (q.bit_cnt == 4'h0)
        d.is_write = q.mosi_s[2];
      else if (q.bit_cnt < bcf_pkg::BIT_FIRST_DATA)
        d.addr = {q.addr[5:0], q.mosi_s[2]};
      else
        d.shift_in = {q.shift_in[6:0], q.mosi_s[2]};
      // Byte boundary wraps back into data for bursts
      if (q.bit_cnt == bcf_pkg::BIT_LAST_DATA)
      begin
        d.bit_cnt = bcf_pkg::BIT_FIRST_DATA;
        d.commit  = 1'b1;
      end
      else
        d.bit_cnt = q.bit_cnt + 4'h1;
    end
    else if (fall)
    begin
      // Write lands on the falling edge after the last data bit
      if (q.commit)
      begin
        if (q.is_write)
        begin
          if (a == bcf_pkg::ADDR_BANK_POINTER)
            d.bank_ptr = q.shift_in[bcf_pkg::BANK_POINTER_W-1:0];
          else if (!(q.bank_ptr == 2'h0 && a == bcf_pkg::ADDR_FRAME_STATUS))
          begin
            d.mem[q.bank_ptr][a] = q.shift_in;
            wi = win_idx(a, bcf_pkg::SYNC_FIRST, bcf_pkg::SYNC_COUNT);
            if (q.bank_ptr == 2'h0 && wi[7] && fs_disable)
              d.active[wi[2:0]] = q.shift_in;
          end
        end
        a           = q.addr + 7'h01;
        d.addr      = a;
        d.commit    = 1'b0;
      end
      // Read data launches on falling edges of the data phase
      if (!q.is_write && q.bit_cnt == bcf_pkg::BIT_FIRST_DATA)
      begin
        rd            = read_reg(q, a);
        d.spi.miso    = rd[7];
        d.shift_out   = {rd[6:0], 1'b0};
        d.spi.miso_oe = 1'b1;
      end
      else if (!q.is_write && q.bit_cnt > bcf_pkg::BIT_FIRST_DATA)
      begin
        d.spi.miso  = q.shift_out[7];
        d.shift_out = {q.shift_out[6:0], 1'b0};
      end
    end

    // Shutter lag timer runs until integration begins
    if (q.lag_pend)
    begin
      d.lag_cnt = q.lag_cnt + 1'b1;
      if (q.lag_cnt >= LAG_LAST)
      begin
        d.lag_pend = 1'b0;
        d.integ    = 1'b1;
      end
    end

    // Frame controller
    case (q.state)
      bcf_pkg::FS_RESET:
        d.state = bcf_pkg::FS_IDLE;
      bcf_pkg::FS_IDLE:
        if (req_rise)
        begin
          start_exp = 1'b1;
          d.state   = bcf_pkg::FS_EXPOSURE;
        end
      bcf_pkg::FS_EXPOSURE:
        // A second request restarts exposure, dropping what was gathered
        if (req_rise)
          start_exp = 1'b1;
        else if (i_exposure_end || q.exp_done)
          to_global_sample_state = 1'b1;
      bcf_pkg::FS_GLOBAL_SAMPLE_STATE:
        // Requests here would corrupt the sample, so they are ignored
        if (q.global_sample_state_cnt >= GLOBAL_SAMPLE_STATE_LAST)
        begin
          d.state = bcf_pkg::FS_READOUT;
          d.integ = 1'b0;
        end
        else
          d.global_sample_state_cnt = q.global_sample_state_cnt + 1'b1;
      bcf_pkg::FS_READOUT:
      begin
        if (req_rise)
        begin
          start_exp  = 1'b1;
          d.exp_run  = 1'b1;
          d.exp_done = 1'b0;
        end
        else if (q.exp_run && i_exposure_end)
          d.exp_done = 1'b1;
        if (i_readout_done && !req_rise)
        begin
          if (!q.exp_run)
            d.state = bcf_pkg::FS_IDLE;
          else if (q.exp_done || i_exposure_end)
            to_global_sample_state = 1'b1;
          else
          begin
            d.state    = bcf_pkg::FS_EXPOSURE;
            d.exp_done = 1'b0;
          end
          d.exp_run = 1'b0;
        end
        else if (i_readout_done)
        begin
          d.state   = bcf_pkg::FS_EXPOSURE;
          d.exp_run = 1'b0;
        end
      end
      default:
        d.state = bcf_pkg::FS_IDLE;
    endcase

    // New exposure: latch timing registers, arm the start lag
    if (start_exp)
    begin
      for (int i = 0; i < bcf_pkg::FRAME_COUNT; i++)
        d.frame_cfg[i] = q.mem[0][bcf_pkg::FRAME_FIRST + 7'(i)];
      d.integ    = no_lag;
      d.lag_pend = ~no_lag;
      d.lag_cnt  = '0;
    end

    // Global sample start: shadow to active unless held
    if (to_global_sample_state)
    begin
      d.state    = bcf_pkg::FS_GLOBAL_SAMPLE_STATE;
      d.global_sample_state_cnt = '0;
      d.exp_done = 1'b0;
      d.lag_pend = 1'b0;
      d.integ    = q.integ | q.lag_pend;
      if (!upd_hold)
        for (int i = 0; i < bcf_pkg::SYNC_COUNT; i++)
          d.active[i] = d.mem[0][bcf_pkg::SYNC_FIRST + 7'(i)];
    end

    // Soft reset holds frame logic only; port and banks keep running
    if (!soft_n)
    begin
      d.state    = bcf_pkg::FS_RESET;
      d.exp_run  = 1'b0;
      d.exp_done = 1'b0;
      d.integ    = 1'b0;
      d.lag_pend = 1'b0;
      d.lag_cnt  = '0;
      d.global_sample_state_cnt = '0;
    end
  end

  // Single state register; hard reset clears everything except the chip-select synchroniser, which starts deselected
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      q          <= '0;
      q.sclk_s   <= 3'h0;
      q.csn_s    <= 3'h7;
      q.csn_f    <= 1'b1;
      q.bank_ptr <= bcf_pkg::BANK_POINTER_RST;
      q.state    <= bcf_pkg::FS_RESET;
    end
    else
      q <= d;
  end

  // Outputs straight from the state register
  assign o_spi              = q.spi;
  assign o_frame_state      = q.state;
  assign o_exposure_overlap = q.exp_run;
  assign o_integrating      = q.integ;
  assign o_active_sync      = q.active;
  assign o_frame_timing     = q.frame_cfg;

endmodule : bcf_config_bank

// *** design/bcf_pkg.sv ***
package bcf_pkg;

  // Bank geometry
  localparam int NUM_BANKS = 4;
  localparam int REG_COUNT = 127;
  localparam int ADDR_W    = 7;
  localparam int DATA_W    = 8;

  // Fixed register offsets, bank 0 except the pointer
  localparam logic [6:0] ADDR_BANK_POINTER       = 7'h00;
  localparam logic [6:0] ADDR_FRAME_SYNC_DISABLE = 7'h01;
  localparam logic [6:0] ADDR_UPDATE_HOLD        = 7'h02;
  localparam logic [6:0] ADDR_SOFT_RESET_CONTROL = 7'h03;
  localparam logic [6:0] ADDR_START_LAG_DISABLE  = 7'h75;
  localparam logic [6:0] ADDR_FRAME_STATUS       = 7'h7F;

  // Category windows in bank 0
  localparam logic [6:0] FRAME_FIRST = 7'h0C;
  localparam int         FRAME_COUNT = 4;
  localparam logic [6:0] SYNC_FIRST  = 7'h10;
  localparam int         SYNC_COUNT  = 8;

  // Field positions and reset values
  localparam int         BANK_POINTER_W         = 2;
  localparam int         CTRL_BIT               = 0;
  localparam logic [1:0] BANK_POINTER_RST       = 2'h0;
  localparam logic [7:0] REG_RST                = 8'h00;
  localparam logic [7:0] FRAME_SYNC_DISABLE_RST = 8'h00;
  localparam logic [7:0] UPDATE_HOLD_RST        = 8'h00;
  localparam logic [7:0] SOFT_RESET_CONTROL_RST = 8'h00;
  localparam logic [7:0] START_LAG_DISABLE_RST  = 8'h00;

  // Serial framing: bit 0 control, 1..7 address, 8..15 data
  localparam logic [3:0] BIT_FIRST_DATA = 4'h8;
  localparam logic [3:0] BIT_LAST_DATA  = 4'hF;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int LAG_TIME_NS   = 200;
  localparam int GLOBAL_SAMPLE_STATE_TIME_NS  = 500;
  localparam int LAG_CYCLES    = (LAG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GLOBAL_SAMPLE_STATE_CYCLES   = (GLOBAL_SAMPLE_STATE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 16;

  typedef enum logic [2:0] {
    FS_RESET,
    FS_IDLE,
    FS_EXPOSURE,
    FS_GLOBAL_SAMPLE_STATE,
    FS_READOUT
  } bcf_frame_state_t;

  // Serial port pins
  typedef struct packed {
    logic sclk;
    logic csn;
    logic mosi;
  } bcf_spi_in_t;

  // Serial data output pin
  typedef struct packed {
    logic miso;
    logic miso_oe;
  } bcf_spi_out_t;

endpackage : bcf_pkg

// *** tb/bcf_config_bank_asserts.sv ***
module bcf_config_bank_asserts #(
  parameter int LAG_CYCLES  = 2,
  parameter int GLOBAL_SAMPLE_STATE_CYCLES = 2
) (
  // Clock and hard reset
  input wire logic                                  i_clk,
  input wire logic                                  i_rst,
  // Pins and status of the block
  input wire bcf_pkg::bcf_spi_in_t                  i_spi,
  input wire bcf_pkg::bcf_spi_out_t                 o_spi,
  input wire logic                                  i_exposure_request,
  input wire logic                                  i_exposure_end,
  input wire logic                                  i_readout_done,
  input wire bcf_pkg::bcf_frame_state_t             o_frame_state,
  input wire logic                                  o_exposure_overlap,
  input wire logic                                  o_integrating,
  input wire logic [bcf_pkg::SYNC_COUNT-1:0][7:0]   o_active_sync,
  input wire logic [bcf_pkg::FRAME_COUNT-1:0][7:0]  o_frame_timing
);
  timeunit 1ns;
  timeprecision 100ps;
  logic        in_idle;
  logic        in_exp;
  logic        in_global_sample_state;
  logic        in_ro;
  logic [15:0] global_sample_state_cnt_q;
  logic [7:0]  req_hist_q;
  logic [5:0]  csn_hist_q;

  // State decodes
  assign in_idle = o_frame_state == bcf_pkg::FS_IDLE;
  assign in_exp  = o_frame_state == bcf_pkg::FS_EXPOSURE;
  assign in_global_sample_state = o_frame_state == bcf_pkg::FS_GLOBAL_SAMPLE_STATE;
  assign in_ro   = o_frame_state == bcf_pkg::FS_READOUT;

  // Histories cover the synchroniser delay of the async pins
  always_ff @(posedge i_clk)
  begin
    req_hist_q <= {req_hist_q[6:0], i_exposure_request};
    csn_hist_q <= {csn_hist_q[4:0], i_spi.csn};
    global_sample_state_cnt_q <= (i_rst || !in_global_sample_state) ? 16'h0000 : global_sample_state_cnt_q + 16'h0001;
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_global_sample_state_end;
    in_global_sample_state ##1 !in_global_sample_state;
  endsequence
  sequence s_ro_done;
    in_ro && i_readout_done;
  endsequence

  exp_to_global_sample_state_a: assert property (in_exp && i_exposure_end |=> in_global_sample_state)
    else $error("exposure end did not enter global sample");
  global_sample_state_len_a: assert property (s_global_sample_state_end |-> global_sample_state_cnt_q == GLOBAL_SAMPLE_STATE_CYCLES && in_ro)
    else $error("global sample length or successor wrong");
  global_sample_state_bound_a: assert property (global_sample_state_cnt_q <= GLOBAL_SAMPLE_STATE_CYCLES)
    else $error("global sample overran");
  ro_idle_a: assert property ((s_ro_done and !o_exposure_overlap) |=> in_idle)
    else $error("readout end without exposure did not idle");
  ro_next_a: assert property ((s_ro_done and o_exposure_overlap) |=> in_exp || in_global_sample_state)
    else $error("readout end with exposure went wrong way");
  idle_exit_a: assert property (o_frame_state == bcf_pkg::FS_RESET ##1 !$stable(o_frame_state)
    |-> in_idle)
    else $error("reset exit not to idle");
  req_start_a: assert property (in_idle && $rose(i_exposure_request) |-> ##[2:6] in_exp)
    else $error("request edge did not start exposure");
  sync_load_a: assert property ($changed(o_active_sync) |-> in_global_sample_state || !(&csn_hist_q))
    else $error("active copy changed outside load points");
  timing_load_a: assert property ($changed(o_frame_timing)
    |-> |(req_hist_q[6:0] & ~req_hist_q[7:1]))
    else $error("frame timing changed without request edge");
  integ_win_a: assert property (o_integrating |-> in_exp || in_global_sample_state || (in_ro && o_exposure_overlap))
    else $error("integrating outside exposure window");
  // Data pin must be let go once the port has been deselected a while
  oe_release_a: assert property (&csn_hist_q |-> !o_spi.miso_oe)
    else $error("data pin still driven after deselect");
endmodule : bcf_config_bank_asserts

bind bcf_config_bank bcf_config_bank_asserts #(
  .LAG_CYCLES (LAG_CYCLES),
  .GLOBAL_SAMPLE_STATE_CYCLES(GLOBAL_SAMPLE_STATE_CYCLES)
) i_asserts (
  .i_clk             (i_clk),
  .i_rst             (i_rst),
  .i_spi             (i_spi),
  .o_spi             (o_spi),
  .i_exposure_request(i_exposure_request),
  .i_exposure_end    (i_exposure_end),
  .i_readout_done    (i_readout_done),
  .o_frame_state     (o_frame_state),
  .o_exposure_overlap(o_exposure_overlap),
  .o_integrating     (o_integrating),
  .o_active_sync     (o_active_sync),
  .o_frame_timing    (o_frame_timing)
);

// *** tb/bcf_spi_master.sv ***
module bcf_spi_master (
  // Serial pins toward the block
  output logic      o_sclk,
  output logic      o_csn,
  output logic      o_mosi,
  input  wire logic i_miso
);
  timeunit 1ns;
  timeprecision 100ps;

  // Clock parked low outside frames
  initial
  begin
    o_sclk = 1'b0;
    o_csn  = 1'b1;
    o_mosi = 1'b1;
  end

  // Launch while low, take read data at the rising edge
  task automatic bit_io(input logic b, output logic r);
    o_mosi = b;
    #62.5 o_sclk = 1'b1;
    r = i_miso;
    #62.5 o_sclk = 1'b0;
  endtask : bit_io

  // Control bit, address and whole bytes, all MSB first
  task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] wq[$],
                      output logic [7:0] rq[$]);
    logic       r;
    logic [7:0] b;
    rq = {};
    o_csn = 1'b0;
    #62.5;
    bit_io(wr, r);
    for (int i = 6; i >= 0; i--)
      bit_io(a[i], r);
    foreach (wq[k])
    begin
      for (int i = 7; i >= 0; i--)
      begin
        bit_io(wq[k][i], r);
        b[i] = r;
      end
      rq.push_back(b);
    end
    #62.5 o_csn = 1'b1;
    // Released line flips so a stale bit cannot pass
    o_mosi = ~o_mosi;
    #250;
  endtask : xfer
endmodule : bcf_spi_master

// *** tb/testbench.sv ***
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int         LAG = 2;
  localparam int         GLB = 2;
  localparam logic [7:0] RS  = {5'h00, bcf_pkg::FS_RESET};
  localparam logic [7:0] ID  = {5'h00, bcf_pkg::FS_IDLE};
  localparam logic [7:0] EX  = {5'h00, bcf_pkg::FS_EXPOSURE};
  localparam logic [7:0] GL  = {5'h00, bcf_pkg::FS_GLOBAL_SAMPLE_STATE};
  localparam logic [7:0] RO  = {5'h00, bcf_pkg::FS_READOUT};
  logic                      i_clk;
  logic                      i_rst;
  logic                      req;
  logic [1:0]                ctl;
  logic                      mon_on;
  logic                      ovl;
  logic                      integ;
  bcf_pkg::bcf_spi_in_t      spi_in;
  bcf_pkg::bcf_spi_out_t     spi_out;
  bcf_pkg::bcf_frame_state_t st;
  bcf_pkg::bcf_frame_state_t st_seen;
  logic [7:0][7:0]           act;
  logic [3:0][7:0]           tim;
  logic [7:0]                exp_q[$];
  logic [7:0]                got_q[$];
  logic [7:0]                st_q[$];
  logic [7:0]                bq[$];
  logic [63:0]               s1;
  logic [63:0]               s2;
  logic [63:0]               s3;
  logic [31:0]               t1;
  logic [31:0]               t2;
  int                        err_count;
  int                        n_tests;

  bcf_config_bank #(.LAG_CYCLES(LAG), .GLOBAL_SAMPLE_STATE_CYCLES(GLB)) i_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_spi(spi_in), .o_spi(spi_out),
    .i_exposure_request(req), .i_exposure_end(ctl[0]), .i_readout_done(ctl[1]),
    .o_frame_state(st), .o_exposure_overlap(ovl), .o_integrating(integ),
    .o_active_sync(act), .o_frame_timing(tim));
  bcf_spi_master i_master (.o_sclk(spi_in.sclk), .o_csn(spi_in.csn), .o_mosi(spi_in.mosi),
    .i_miso(spi_out.miso));

  always #5 i_clk = ~i_clk;

  task check(input logic [63:0] seen, input logic [63:0] want);
    n_tests++;
    if (seen !== want)
    begin
      err_count++;
      $display("mismatch at %0t: got %h, expected %h", $time, seen, want);
    end
  endtask : check

  task report_and_stop;
    $display("comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  task wr(input logic [6:0] a, input logic [7:0] q[$]);
    logic [7:0] r[$];
    i_master.xfer(1'b1, a, q, r);
  endtask : wr

  // Expected bytes are noted before the read starts
  task rd(input logic [6:0] a, input logic [7:0] e[$]);
    logic [7:0] r[$];
    foreach (e[i]) exp_q.push_back(e[i]);
    i_master.xfer(1'b0, a, e, r);
    foreach (r[i]) got_q.push_back(r[i]);
  endtask : rd

  task pulse(input logic [1:0] v);
    @(negedge i_clk) ctl = v;
    @(negedge i_clk) ctl = 2'h0;
    repeat (5) @(negedge i_clk);
  endtask : pulse

  // Raise request, wait for exposure or overlap, check the sampled outputs
  task expose(input logic want_integ, input logic [31:0] want_tim);
    @(negedge i_clk) req = 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      @(negedge i_clk);
      if (ovl === 1'b1 || st === bcf_pkg::FS_EXPOSURE) break;
    end
    check(integ, want_integ);
    check(tim, want_tim);
    req = 1'b0;
  endtask : expose

  // Result watcher: read bytes and every state change
  always @(negedge i_clk)
  begin
    while (got_q.size() > 0) check(got_q.pop_front(), exp_q.pop_front());
    if (mon_on && st !== st_seen)
    begin
      st_seen = st;
      check(st, st_q.size() > 0 ? st_q.pop_front() : 8'hFF);
    end
  end

  initial
  begin
    #400000;
    err_count++;
    report_and_stop;
  end

  initial
  begin
    void'($urandom(32'h572c9e66));
    {i_clk, i_rst, req, ctl, mon_on, err_count, n_tests} = {1'b0, 1'b1, 4'h0, 64'h0};
    st_seen = bcf_pkg::FS_RESET;
    {s1, s2, s3, t1, t2} = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom,
                            $urandom, $urandom};
    repeat (2) @(negedge i_clk);
    i_rst = 1'b0;
    mon_on = 1'b1;
    repeat (3) @(negedge i_clk);
    // Reset values, then pointer width and banks kept apart
    rd(7'h00, '{8'h00, 8'h00, 8'h00, 8'h00});
    check(spi_out.miso_oe, 1'b0);
    rd(bcf_pkg::ADDR_START_LAG_DISABLE, '{8'h00});
    wr(7'h00, '{8'hFF});
    rd(7'h00, '{8'h03});
    wr(7'h05, '{s1[7:0]});
    wr(7'h00, '{8'h01});
    wr(7'h05, '{s2[7:0]});
    rd(7'h00, '{8'h01});
    wr(7'h00, '{8'h03});
    rd(7'h05, '{s1[7:0]});
    // Burst runs over read-only status and wraps onto the pointer
    wr(7'h00, '{8'h00});
    wr(7'h7E, '{s3[7:0], 8'h5A, 8'h02});
    rd(7'h00, '{8'h02});
    wr(7'h00, '{8'h00});
    rd(7'h7E, '{s3[7:0], RS});
    // Settings staged in soft reset, then released
    bq = {<<8{s1}};
    wr(bcf_pkg::SYNC_FIRST, bq);
    rd(bcf_pkg::SYNC_FIRST, bq);
    bq = {<<8{t1}};
    wr(bcf_pkg::FRAME_FIRST, bq);
    check(act, 64'h0);
    st_q = '{ID, EX, GL, RO, ID};
    wr(bcf_pkg::ADDR_SOFT_RESET_CONTROL, '{8'h01});
    // Sequential frame with start lag
    expose(1'b0, t1);
    repeat (LAG + 1) @(negedge i_clk);
    check(integ, 1'b1);
    pulse(2'b01);
    check(act, s1);
    pulse(2'b10);
    // Held upload, no lag, both pipelined readout endings
    wr(bcf_pkg::ADDR_UPDATE_HOLD, '{8'h01});
    bq = {<<8{s2}};
    wr(bcf_pkg::SYNC_FIRST, bq);
    wr(bcf_pkg::ADDR_START_LAG_DISABLE, '{8'h01});
    st_q = '{EX, GL, RO, EX, GL, RO, GL, RO, ID};
    expose(1'b1, t1);
    bq = {<<8{t2}};
    wr(bcf_pkg::FRAME_FIRST, bq);
    check(tim, t1);
    pulse(2'b01);
    check(act, s1);
    expose(1'b1, t2);
    check(ovl, 1'b1);
    pulse(2'b10);
    check(ovl, 1'b0);
    pulse(2'b01);
    expose(1'b1, t2);
    pulse(2'b01);
    check(ovl, 1'b1);
    pulse(2'b10);
    pulse(2'b10);
    check(ovl, 1'b0);
    // Frame sync off: write acts at once
    wr(bcf_pkg::ADDR_UPDATE_HOLD, '{8'h00});
    wr(bcf_pkg::ADDR_FRAME_SYNC_DISABLE, '{8'h01});
    bq = {<<8{s3}};
    wr(bcf_pkg::SYNC_FIRST, bq);
    check(act, s3);
    // Soft reset keeps registers, hard reset clears them
    st_q = '{RS, ID, RS};
    wr(bcf_pkg::ADDR_SOFT_RESET_CONTROL, '{8'h00});
    rd(bcf_pkg::ADDR_START_LAG_DISABLE, '{8'h01});
    check(act, s3);
    wr(bcf_pkg::ADDR_SOFT_RESET_CONTROL, '{8'h01});
    @(negedge i_clk) i_rst = 1'b1;
    repeat (2) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (3) @(negedge i_clk);
    rd(bcf_pkg::ADDR_START_LAG_DISABLE, '{8'h00});
    check(act, 64'h0);
    repeat (4) @(negedge i_clk);
    report_and_stop;
  end
endmodule : testbench
